// [src/smc_master.sv]
/*
 smc_master: simple i2c master channel with delay timer, byte gap and AHB-Lite registers.
 assumes open-drain bus lines resolved outside; single whole-word AHB transfers.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_master
	import smc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic bus_clock_line_in,
	output logic bus_clock_line_out,
	output logic bus_clock_line_oe_out,
	input wire logic bus_data_line_in,
	output logic bus_data_line_out,
	output logic bus_data_line_oe_out,
	output logic irq_out
);
	localparam int TD2 = DELAY_CYC - 2;

	////////////////////////////////////////////////////////////////////
	// bus slave
	smc_ahb_s ap_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	wire logic ap_go = hsel_in && htrans_in[1] && hready_in;
	wire logic rd_go = ap_go && !hwrite_in;
	wire logic [11:0] ra = haddr_in[11:0];
	wire logic wr_go = ap_q.vld && ap_q.wr;
	wire logic [11:0] wa = ap_q.addr;
	wire logic [31:0] wd = hwdata_in;
	wire logic [2:0] unused_size = hsize_in;
	logic [31:0] rd_mux;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ap_q <= '0;
		else if (hready_in)
			ap_q <= '{addr: ra, wr: hwrite_in, vld: ap_go};
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			hrdata_q <= '0;
		else
			hrdata_q <= rd_go ? rd_mux : 32'h0;
	end

	always_ff @(posedge clk_in)
	begin
		hreadyout_q <= 1'b1;
		hresp_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// register strobes
	wire logic w_clr = wr_go && wa == OFF_FLAG_CLR;
	wire logic w_data = wr_go && wa == OFF_DATA;
	wire logic w_stop = wr_go && wa == OFF_STOP && wd[STOP_BIT];
	wire logic w_start = wr_go && wa == OFF_START && wd[START_BIT];
	wire logic w_mode = wr_go && wa == OFF_MODE;
	wire logic w_soe = wr_go && wa == OFF_OUT_EN;
	wire logic w_ts = wr_go && wa == OFF_TMR_START && wd[TS_BIT];
	wire logic w_lvl = wr_go && wa == OFF_LINE_LVL;
	wire logic w_gap = wr_go && wa == OFF_GAP;
	wire logic w_msk = wr_go && wa == OFF_IRQ_MSK;
	wire logic r_ist = rd_go && ra == OFF_IRQ_ST;

	logic [15:0] mode_q;
	logic soe_q;
	logic lvl_dat_q;
	logic lvl_clk_q;
	logic [7:0] gap_reg_q;
	logic [2:0] msk_q;
	logic se_q;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			mode_q <= MODE_RESET;
			soe_q <= 1'b0;
			lvl_dat_q <= 1'b1;
			lvl_clk_q <= 1'b1;
			gap_reg_q <= GAP_RESET;
			msk_q <= '0;
		end
		else
		begin
			if (w_mode)
				mode_q <= wd[15:0]; // see [R5]
			if (w_soe)
				soe_q <= wd[SOE_BIT]; // see [R7]
			if (w_lvl)
			begin
				lvl_dat_q <= wd[LVL_DAT]; // see [R16] see [R17]
				lvl_clk_q <= wd[LVL_CLK];
			end
			if (w_gap)
				gap_reg_q <= wd[7:0]; // see [R18]
			if (w_msk)
				msk_q <= wd[2:0];
		end
	end

	// stop wins over a start written in the same word order
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || w_stop)
			se_q <= 1'b0; // see [R3]
		else if (w_start)
			se_q <= 1'b1; // see [R4]
	end

	////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [1:0] dsync_q;
	logic [1:0] csync_q;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			dsync_q <= 2'h3;
			csync_q <= 2'h3;
		end
		else
		begin
			dsync_q <= {dsync_q[0], bus_data_line_in};
			csync_q <= {csync_q[0], bus_clock_line_in};
		end
	end

	wire logic sda_s = dsync_q[1];

	////////////////////////////////////////////////////////////////////
	// byte shifter
	smc_shift_e sh_st_q;
	logic [6:0] hc_q;
	logic [3:0] bc_q;
	logic [7:0] sh_q;
	logic smp_q;
	logic pend_q;
	logic gap_q;
	logic gap_done;

	wire logic [1:0] mode = mode_q[MODE_HI:MODE_LO];
	wire logic tx_m = mode == MODE_TX;
	wire logic mode_ok = se_q && (mode == MODE_TX || mode == MODE_RX); // see [R5]
	wire logic busy = sh_st_q != SH_IDLE;
	wire logic go_req = w_data && mode_ok && !busy && !pend_q; // see [R6]
	wire logic launch = (go_req && !gap_q) || (pend_q && gap_done); // see [R11]
	wire logic half_end = hc_q == 7'(HALF_CYC - 1); // see [R15]
	wire logic mid = hc_q == 7'(HALF_CYC / 2);
	wire logic last_bit = bc_q == LAST_BIT;
	wire logic hi = sh_st_q == SH_HIGH;
	wire logic samp = hi && mid;
	wire logic bit_end = hi && half_end;
	wire logic done = bit_end && last_bit; // see [R10]
	wire logic frm_set = w_data && se_q && mode == (MODE_TX | MODE_RX);
	wire logic ovr_set = w_data && (busy || pend_q);
	wire logic nack_set = samp && last_bit && tx_m && sda_s; // see [R1]

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || w_stop)
			sh_st_q <= SH_IDLE;
		else
			case (sh_st_q)
				SH_IDLE:
					if (launch)
						sh_st_q <= SH_LOW;
				SH_LOW:
					if (half_end)
						sh_st_q <= SH_HIGH;
				SH_HIGH:
					if (half_end)
						sh_st_q <= last_bit ? SH_IDLE : SH_LOW;
				default:
					sh_st_q <= SH_IDLE;
			endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || !busy || half_end)
			hc_q <= '0;
		else
			hc_q <= hc_q + 7'h1;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || launch)
			bc_q <= '0;
		else if (bit_end && !last_bit)
			bc_q <= bc_q + 4'h1;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			sh_q <= '0;
			smp_q <= 1'b1;
		end
		else
		begin
			if (w_data && !busy && !pend_q)
				sh_q <= wd[7:0];
			else if (bit_end && !last_bit)
				sh_q <= {sh_q[6:0], smp_q};
			if (samp)
				smp_q <= sda_s;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || w_stop || launch)
			pend_q <= 1'b0;
		else if (go_req && gap_q)
			pend_q <= 1'b1; // see [R10]
	end

	////////////////////////////////////////////////////////////////////
	// flags, set wins over clear
	logic nack_q;
	logic fef_q;
	logic ovf_q;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			nack_q <= 1'b0;
			fef_q <= 1'b0;
			ovf_q <= 1'b0;
		end
		else
		begin
			nack_q <= nack_set || (nack_q && !(w_clr && wd[CLR_NACK])); // see [R2]
			fef_q <= frm_set || (fef_q && !(w_clr && wd[CLR_FRM]));
			ovf_q <= ovr_set || (ovf_q && !(w_clr && wd[CLR_OVR]));
		end
	end

	////////////////////////////////////////////////////////////////////
	// delay timer and byte gap
	logic [15:0] tmr_q;
	logic run_q;
	logic [7:0] gcnt_q;
	wire logic tmr_exp = run_q && tmr_q == 16'h0;
	wire logic more = ({1'b0, gcnt_q} + 9'h1) < {1'b0, gap_reg_q};
	wire logic gap_next = gap_q && tmr_exp && more;
	assign gap_done = gap_q && tmr_exp && !more; // see [R11]
	wire logic tmr_go = w_ts || done || gap_next; // see [R8] see [R11] see [R13]

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			tmr_q <= '0;
			run_q <= 1'b0;
		end
		else if (tmr_go)
		begin
			tmr_q <= 16'(DELAY_CYC - 1); // see [R12]
			run_q <= 1'b1;
		end
		else if (run_q)
		begin
			tmr_q <= tmr_q - 16'h1;
			run_q <= !tmr_exp;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			gap_q <= 1'b0;
			gcnt_q <= '0;
		end
		else if (done)
		begin
			gap_q <= 1'b1; // see [R9] see [R10]
			gcnt_q <= '0;
		end
		else
		begin
			if (gap_done)
				gap_q <= 1'b0;
			if (gap_next)
				gcnt_q <= gcnt_q + 8'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// line drive
	wire logic tx_bit = soe_q ? sh_q[7] : lvl_dat_q;
	wire logic ack_bit = soe_q ? 1'b0 : lvl_dat_q; // see [R7]
	wire logic bit_lvl = last_bit ? (tx_m ? 1'b1 : ack_bit) : (tx_m ? tx_bit : 1'b1);
	wire logic clk_lvl = busy ? hi : (mode_ok ? 1'b0 : lvl_clk_q); // see [R17]
	wire logic dat_lvl = busy ? bit_lvl : lvl_dat_q; // see [R16]
	logic scl_oe_q;
	logic sda_oe_q;
	logic od_low_q;

	// no wait on a held clock: the shifter never looks at the clock line
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			scl_oe_q <= !clk_lvl; // see [R9]
			sda_oe_q <= !dat_lvl;
		end
		od_low_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// interrupts
	smc_evt_s ist_q;
	logic irq_q;
	wire smc_evt_s evt = '{gap_done: gap_done, tmr_exp: tmr_exp, byte_done: done};

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			ist_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			ist_q <= evt | (r_ist ? 3'h0 : ist_q);
			irq_q <= |(ist_q & msk_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// read mux
	wire logic [7:0] stat_byte = {2'h0, busy, 2'h0, fef_q, nack_q, ovf_q};

	assign rd_mux =
		(ra == OFF_STATUS) ? {24'h0, stat_byte} :
		(ra == OFF_DATA) ? {24'h0, sh_q} :
		(ra == OFF_MODE) ? {16'h0, mode_q} :
		(ra == OFF_START) ? {31'h0, se_q} :
		(ra == OFF_OUT_EN) ? {31'h0, soe_q} :
		(ra == OFF_LINE_LVL) ? {22'h0, csync_q[1], lvl_clk_q, 6'h0, sda_s, lvl_dat_q} :
		(ra == OFF_GAP) ? {24'h0, gap_reg_q} :
		(ra == OFF_IRQ_ST) ? {29'h0, ist_q} :
		(ra == OFF_IRQ_MSK) ? {29'h0, msk_q} :
		32'h0;

	assign hrdata_out = hrdata_q;
	assign hreadyout_out = hreadyout_q;
	assign hresp_out = hresp_q;
	assign bus_clock_line_out = od_low_q;
	assign bus_clock_line_oe_out = scl_oe_q;
	assign bus_data_line_out = od_low_q;
	assign bus_data_line_oe_out = sda_oe_q;
	assign irq_out = irq_q;

	////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_tmr_quiet;
		(!tmr_go) throughout ##TD2 1'b1;
	endsequence

	sequence s_last_high;
		hi && last_bit && mid;
	endsequence

	property p_start_en;
		@(posedge clk_in) disable iff (!rst_n_in)
		(w_start && !w_stop) |=> se_q;
	endproperty
	a_start_en: assert property (p_start_en) else $error("start did not enable"); // see [R4]

	property p_stop_halt;
		@(posedge clk_in) disable iff (!rst_n_in)
		w_stop |=> !se_q && !busy ##1 !busy;
	endproperty
	a_stop_halt: assert property (p_stop_halt) else $error("stop did not halt"); // see [R3]

	property p_nack_clr;
		@(posedge clk_in) disable iff (!rst_n_in)
		(w_clr && wd[CLR_NACK] && !nack_set) |=> !nack_q;
	endproperty
	a_nack_clr: assert property (p_nack_clr) else $error("nack flag not cleared"); // see [R2]

	property p_nack_tx;
		@(posedge clk_in) disable iff (!rst_n_in)
		(s_last_high and (tx_m && sda_s)) |=> nack_q;
	endproperty
	a_nack_tx: assert property (p_nack_tx) else $error("slave nack not flagged"); // see [R1]

	property p_mode_bad;
		@(posedge clk_in) disable iff (!rst_n_in)
		(w_data && mode == (MODE_TX | MODE_RX) && !busy) |=> !busy [*2];
	endproperty
	a_mode_bad: assert property (p_mode_bad) else $error("prohibited mode started"); // see [R5]

	property p_tmr_len;
		@(posedge clk_in) disable iff (!rst_n_in)
		tmr_go ##1 s_tmr_quiet |=> tmr_exp;
	endproperty
	a_tmr_len: assert property (p_tmr_len) else $error("delay length wrong"); // see [R12]

	property p_gap_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		done |=> (gap_q && !busy) [*8];
	endproperty
	a_gap_hold: assert property (p_gap_hold) else $error("no gap after byte"); // see [R10]

	property p_gap_start;
		@(posedge clk_in) disable iff (!rst_n_in)
		done |=> run_q && tmr_q == 16'(DELAY_CYC - 1);
	endproperty
	a_gap_start: assert property (p_gap_start) else $error("byte done left timer idle"); // see [R11]

	property p_ack_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		(s_last_high and (!tx_m && !soe_q && lvl_dat_q)) |=> !sda_oe_q;
	endproperty
	a_ack_off: assert property (p_ack_off) else $error("ack driven while disabled"); // see [R7]

	property p_irq;
		@(posedge clk_in) disable iff (!rst_n_in)
		(|(ist_q & msk_q)) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule
`default_nettype wire

// [src/smc_pkg.sv]
/*
 smc_pkg: constants, register map and carrier types of the simple i2c master channel.
 assumes a 40 MHz system clock and a 32-bit AHB-Lite register port.
*/
// Behaviour
// [R1] status bit 1 reads 0 after slave ack, 1 after slave nack
// [R2] writing 1 to flag-clear bit 1 clears nack flag; neighbours clear framing, overrun
// [R3] stop trigger bit 0 clears channel enabled status and halts communication
// [R4] start trigger bit 0 sets channel enabled status, channel waits for data
// [R5] mode bits 15:14: 00 off, 01 receive, 10 transmit, 11 prohibited
// [R6] to receive: stop, set receive mode, start, then write dummy 0xff
// [R7] clearing output enable bit 0 stops serial drive, withholding the master ack; the code keeps clocking and drives data from line level bit 0
// [R8] timer start bit 3 written 1 starts the delay timer counting
// [R9] no clock stretching; all master-slave timing comes from inserted delays
// [R10] after each nine-clock byte the master waits a gap before next transfer
// [R11] byte done starts timer; next transfer runs after gap count expiries
// [R12] delay timer is a 16-bit one-shot of 5 us per trigger
// [R13] the same 5 us delay serves around start and stop conditions
// [R14] slave takes its wait point at ninth clock, finishes within the gap
// [R15] bus bit rate is 200000 bits per second
// [R16] stop: data low, clock high, data high, with transmit and receive off
// [R17] start: both high, data low, then clock low before transmit is enabled
// [R18] gap count is a loadable register so the gap can be lengthened
package smc_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned BIT_RATE = 200_000; // see [R15]
	localparam int unsigned HALF_CYC = CLK_HZ / BIT_RATE / 2;
	localparam int unsigned DELAY_NS = 5_000; // see [R12]
	localparam int unsigned DELAY_CYC = (DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned GAP_NS = 20_000;
	localparam logic [7:0] GAP_RESET = 8'(GAP_NS / DELAY_NS);
	localparam logic [3:0] LAST_BIT = 4'h8;

	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_FLAG_CLR = 12'h004;
	localparam logic [11:0] OFF_DATA = 12'h008;
	localparam logic [11:0] OFF_STOP = 12'h00c;
	localparam logic [11:0] OFF_MODE = 12'h010;
	localparam logic [11:0] OFF_START = 12'h014;
	localparam logic [11:0] OFF_OUT_EN = 12'h018;
	localparam logic [11:0] OFF_TMR_START = 12'h01c;
	localparam logic [11:0] OFF_LINE_LVL = 12'h020;
	localparam logic [11:0] OFF_GAP = 12'h024;
	localparam logic [11:0] OFF_IRQ_ST = 12'h028;
	localparam logic [11:0] OFF_IRQ_MSK = 12'h02c;

	localparam int unsigned CLR_OVR = 0;
	localparam int unsigned CLR_NACK = 1;
	localparam int unsigned CLR_FRM = 2;
	localparam int unsigned STOP_BIT = 0;
	localparam int unsigned START_BIT = 0;
	localparam int unsigned SOE_BIT = 0;
	localparam int unsigned TS_BIT = 3;
	localparam int unsigned LVL_DAT = 0;
	localparam int unsigned LVL_CLK = 8;
	localparam int unsigned MODE_HI = 15;
	localparam int unsigned MODE_LO = 14;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_RX = 2'h1;
	localparam logic [1:0] MODE_TX = 2'h2;
	localparam logic [15:0] MODE_RESET = 16'h0017;
	localparam logic [7:0] DUMMY_RX = 8'hff;

	typedef enum {SH_IDLE, SH_LOW, SH_HIGH} smc_shift_e;

	typedef struct packed {
		logic [11:0] addr;
		logic wr;
		logic vld;
	} smc_ahb_s;

	typedef struct packed {
		logic gap_done;
		logic tmr_exp;
		logic byte_done;
	} smc_evt_s;
endpackage

// [testbench/smc_slave_model.sv]
/*
 smc_slave_model: behavioural i2c slave on the resolved bus lines.
 assumes pulled-up open-drain lines; a start or stop condition marks a new frame.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_slave_model
(
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic ack_en_in,
	input wire logic tx_mode_in,
	input wire logic [7:0] tx_byte_in,
	output logic sda_oe_out,
	output logic [7:0] rx_byte_out,
	output logic ack_seen_out
);
////////////////////////////////////////
	logic [7:0] sh_q;
	int cnt;
	logic pull = 1'b0;
	initial
	begin
		rx_byte_out = 8'h00;
		ack_seen_out = 1'b1;
		sh_q = 8'h00;
		cnt = 0;
	end
	assign sda_oe_out = pull;
	// never holds the clock; byte work is done at the ninth clock
	always @(posedge scl_in)
	begin
		if (cnt == 8)
		begin
			ack_seen_out = sda_in;
			cnt = 0;
		end
		else
		begin
			sh_q = {sh_q[6:0], sda_in};
			rx_byte_out = sh_q;
			cnt++;
		end
	end
	// data moving while the clock stays high is a start or stop: new frame
	always @(sda_in)
	begin
		#1;
		if (scl_in === 1'b1)
			cnt = 0;
	end
	// drive changes only while the clock is low; released lines float high
	always @(scl_in or cnt or tx_mode_in or tx_byte_in or ack_en_in)
	begin
		if (scl_in !== 1'b1)
		begin
			if (tx_mode_in)
				pull = (cnt < 8) ? !tx_byte_in[7 - cnt] : 1'b0;
			else
				pull = (cnt == 8) && ack_en_in;
		end
	end
endmodule
`default_nettype wire

// [testbench/smc_master_tb_top.sv]
/*
 smc_master_tb_top: register-level tests of the i2c master channel.
 assumes zero-wait AHB-Lite slave and the slave model on pulled-up lines.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_master_tb_top
	import smc_pkg::*;
;
	logic clk, rst_n, hsel, hwrite, hready, hresp, irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, hr_q, v;
	logic scl_oe, scl_o, sda_oe, sda_o, s_oe, ack_en, s_tx, ack_seen, scl, sda;
	logic [7:0] tx_byte, rx_byte;
	int miscompares, checked, n;
	realtime t0, per;
	logic [11:0] ra [9] = '{OFF_MODE, OFF_OUT_EN, OFF_LINE_LVL, OFF_GAP, OFF_IRQ_MSK,
		OFF_STATUS, OFF_IRQ_ST, OFF_START, 12'h030};
	logic [31:0] rv [9] = '{32'h17, 32'h0, 32'h303, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
////////////////////////////////////////
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_oe ? sda_o : 1'b1) & !s_oe;
	smc_master smc_master_inst (.clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .bus_clock_line_in(scl),
		.bus_clock_line_out(scl_o), .bus_clock_line_oe_out(scl_oe),
		.bus_data_line_in(sda), .bus_data_line_out(sda_o),
		.bus_data_line_oe_out(sda_oe), .irq_out(irq));
	smc_slave_model smc_slave_model_inst (.scl_in(scl), .sda_in(sda), .ack_en_in(ack_en),
		.tx_mode_in(s_tx), .tx_byte_in(tx_byte), .sda_oe_out(s_oe),
		.rx_byte_out(rx_byte), .ack_seen_out(ack_seen));
	always @(posedge clk) hr_q <= hrdata;
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
////////////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		#1;
		r = hr_q;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		bus(a, 1'b0, 32'h0, r);
	endtask
	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic lines(input logic c, input logic d);
		cyc(3);
		check("clock line", scl, c);
		check("data line", sda, d);
	endtask
	task automatic wait_irq();
		n = 0;
		while (irq !== 1'b1 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000)
			miscompares++;
	endtask
	task automatic xfer(input logic [7:0] d);
		wr(OFF_DATA, {24'h0, d});
		rd(OFF_STATUS, v);
		check("transfer active", v[5], 1'b1);
		wr(OFF_DATA, 32'h0);
		fork
			wait_irq();
			begin
				@(posedge scl);
				t0 = $realtime;
				@(posedge scl);
				per = $realtime - t0;
			end
		join
		check("bit period", int'(per), 5000);
	endtask
	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
////////////////////////////////////////
	initial
	begin
		#2_000_000;
		miscompares++;
		test_done();
	end
	initial
	begin
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hsize = 3'h2;
		rst_n = 1'b0;
		ack_en = 1'b1;
		s_tx = 1'b0;
		tx_byte = 8'h00;
		miscompares = 0;
		checked = 0;
		cyc(10);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (ra[i])
		begin
			rd(ra[i], v);
			check("reset value", v, rv[i]);
		end
		lines(1'b1, 1'b1);
		wr(OFF_LINE_LVL, 32'h100);
		lines(1'b1, 1'b0);
		wr(OFF_LINE_LVL, 32'h0);
		lines(1'b0, 1'b0);
		wr(OFF_IRQ_MSK, 32'h2);
		wr(OFF_TMR_START, 32'h8);
		wait_irq();
		check("timer delay", n >= 197 && n <= 203, 1'b1);
		rd(OFF_IRQ_ST, v);
		check("timer event", v, 32'h2);
		rd(OFF_IRQ_ST, v);
		check("read clear", v, 32'h0);
		cyc(2);
		check("irq low", irq, 1'b0);
		wr(OFF_TMR_START, 32'h7);
		cyc(250);
		rd(OFF_IRQ_ST, v);
		check("no trigger", v, 32'h0);
		wr(OFF_IRQ_MSK, 32'h0);
		wr(OFF_TMR_START, 32'h8);
		cyc(250);
		check("masked irq", irq, 1'b0);
		rd(OFF_IRQ_ST, v);
		check("sticky event", v, 32'h2);
		wr(OFF_MODE, 32'h8017);
		wr(OFF_START, 32'h1);
		rd(OFF_START, v);
		check("enabled", v[0], 1'b1);
		wr(OFF_OUT_EN, 32'h1);
		wr(OFF_IRQ_MSK, 32'h4);
		xfer(8'ha5);
		check("byte gap", n >= 2590 && n <= 2610, 1'b1);
		check("slave byte", rx_byte, 8'ha5);
		rd(OFF_STATUS, v);
		check("ack flag", v[1], 1'b0);
		check("overrun", v[0], 1'b1);
		rd(OFF_IRQ_ST, v);
		check("byte events", v[0] & v[2], 1'b1);
		ack_en = 1'b0;
		wr(OFF_GAP, 32'h8);
		xfer(8'h5a);
		check("long gap", n >= 3390 && n <= 3410, 1'b1);
		check("slave byte", rx_byte, 8'h5a);
		rd(OFF_STATUS, v);
		check("nack flag", v[1], 1'b1);
		wr(OFF_FLAG_CLR, 32'h0);
		rd(OFF_STATUS, v);
		check("nack kept", v[1], 1'b1);
		wr(OFF_FLAG_CLR, 32'h2);
		rd(OFF_STATUS, v);
		check("nack cleared", v[1], 1'b0);
		rd(OFF_IRQ_ST, v);
		wr(OFF_MODE, 32'hc017);
		wr(OFF_DATA, 32'h11);
		rd(OFF_STATUS, v);
		check("bad mode", v[2], 1'b1);
		check("no transfer", v[5], 1'b0);
		wr(OFF_FLAG_CLR, 32'h7);
		rd(OFF_STATUS, v);
		check("flags cleared", v[2:0], 3'h0);
		wr(OFF_STOP, 32'h1);
		rd(OFF_START, v);
		check("disabled", v[0], 1'b0);
		wr(OFF_MODE, 32'h17);
		lines(1'b0, 1'b0);
		wr(OFF_LINE_LVL, 32'h100);
		lines(1'b1, 1'b0);
		wr(OFF_LINE_LVL, 32'h101);
		lines(1'b1, 1'b1);
		wr(OFF_MODE, 32'h4017);
		wr(OFF_START, 32'h1);
		s_tx = 1'b1;
		tx_byte = 8'h3c;
		xfer(DUMMY_RX);
		rd(OFF_DATA, v);
		check("rx byte", v[7:0], 8'h3c);
		check("master ack", ack_seen, 1'b0);
		rd(OFF_IRQ_ST, v);
		wr(OFF_OUT_EN, 32'h0);
		tx_byte = 8'hc3;
		xfer(DUMMY_RX);
		rd(OFF_DATA, v);
		check("rx byte", v[7:0], 8'hc3);
		check("master nack", ack_seen, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
